/* rtl/prxd_phy.sv */
// transceiver end: mii clocks, receive fifo, shadow diagnostic registers
`timescale 1ns/100ps
module prxd_phy
  import prxd_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  prxd_mii_if.phy         mii,
  input  wire logic       link_up_in,
  input  wire logic [7:0] noise_in,
  input  wire logic       line_active_in,
  input  wire logic       line_wr_in,
  input  wire logic [3:0] line_nibble_in,
  input  wire logic       line_err_in,
  output logic            line_ready_out,
  output logic            tx_valid_out,
  output logic      [3:0] tx_nibble_out
);
  typedef enum logic [1:0] {RX_IDLE, RX_LEAD, RX_DATA} prxd_rx_t;
  typedef enum logic {MD_HUNT, MD_FRAME} prxd_md_t;
  typedef struct packed {
    logic [1:0]       ph;
    logic             mii_clk;
    logic             shadow_en;
    logic [5:0]       test_low;
    logic [3:0]       depth;
    logic [7:0]       noise;
    logic [15:0]      pkt_len;
    logic [16:0]      nib_cnt;
    logic [15:0][4:0] fifo;
    logic [3:0]       wptr;
    logic [3:0]       rptr;
    logic [4:0]       fill;
    prxd_rx_t         rx_st;
    logic [2:0]       lead;
    logic [2:0]       eop;
    logic             crs;
    logic             col;
    logic             dv;
    logic             er;
    logic [3:0]       rxd;
    logic             txen;
    logic             txv;
    logic [3:0]       txn;
    prxd_md_t         md_st;
    logic [4:0]       bit_no;
    logic [15:0]      sr;
    logic [4:0]       rad;
    logic             mdc_q;
    logic             is_rd;
    logic             is_wr;
    logic             drv;
    logic [16:0]      osr;
  } prxd_phy_st_t;

  prxd_phy_st_t s;
  prxd_phy_st_t n;
  logic         push;
  logic         pop;
  logic         launch;
  logic         mrise;
  logic [4:0]   cap;
  logic [3:0]   fill_rep;

  // ****************************************
  // register read view
  // ****************************************
  function automatic logic [15:0] rd_mux(input logic [4:0] a);
    logic [15:0] v;
    v = 16'h0;
    if (a == REG_TEST) begin
      v = {8'h00, s.shadow_en, 1'b0, s.test_low};
    end else if (s.shadow_en) begin
      if (a == REG_LINE_QUALITY) begin
        v = {s.noise, 4'h0, fill_rep};
      end else if (a == REG_FIFO_DEPTH) begin
        v = {12'h000, s.depth};
      end else if (a == REG_PKT_LEN) begin
        v = s.pkt_len;
      end
    end
    return v;
  endfunction

  assign cap = depth_nibbles(s.depth);
  assign fill_rep = (s.fill > 5'hf) ? 4'hf : s.fill[3:0];
  assign line_ready_out = s.fill < cap;
  assign push = line_wr_in && line_ready_out;
  assign launch = (s.ph == MII_HALF - 2'h1);
  assign mrise = mii.mdc && !s.mdc_q;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    pop = 1'b0;
    // free-running 40 ns clock, 20 ns high and 20 ns low
    n.ph = (s.ph == MII_LAST) ? 2'h0 : s.ph + 2'h1;
    n.mii_clk = (n.ph < MII_HALF);
    n.noise = link_up_in ? noise_in : 8'h00;
    n.txv = 1'b0;
    if (s.ph == 2'h0) begin
      n.txen = mii.tx_en;
      n.txv = mii.tx_en;
      n.txn = mii.txd;
    end
    if (line_active_in) begin
      n.crs = 1'b1;
      n.eop = 3'h0;
    end else if (s.crs) begin
      if (s.eop == CRS_EOP_CYC - 3'h1) begin
        n.crs = 1'b0;
      end else begin
        n.eop = s.eop + 3'h1;
      end
    end
    n.col = n.crs && n.txen;
    unique case (s.rx_st)
      RX_IDLE: begin
        if (line_active_in) begin
          n.lead = 3'h0;
          n.nib_cnt = 17'h0;
          n.rx_st = RX_LEAD;
        end
      end
      RX_LEAD: begin
        if (s.lead == RXDV_LEAD_CYC - 3'h1) begin
          n.rx_st = RX_DATA;
        end else begin
          n.lead = s.lead + 3'h1;
        end
      end
      RX_DATA: begin
        if (launch) begin
          if (s.fill != 5'h0) begin
            pop = 1'b1;
            n.dv = 1'b1;
            n.rxd = s.fifo[s.rptr][3:0];
            n.er = s.fifo[s.rptr][4];
            n.nib_cnt = s.nib_cnt + 17'h1;
          end else if (!line_active_in) begin
            if (s.dv) begin
              n.pkt_len = s.nib_cnt[16:1];
            end
            n.dv = 1'b0;
            n.er = 1'b0;
            n.rx_st = RX_IDLE;
          end
        end
      end
    endcase
    if (push) begin
      n.fifo[s.wptr] = {line_err_in, line_nibble_in};
      n.wptr = s.wptr + 4'h1;
    end
    if (pop) begin
      n.rptr = s.rptr + 4'h1;
    end
    n.fill = s.fill + {4'h0, push} - {4'h0, pop};
    // management frame receiver
    n.mdc_q = mii.mdc;
    unique case (s.md_st)
      MD_HUNT: begin
        if (mrise) begin
          n.sr = {s.sr[14:0], mii.mdio};
          if (!s.sr[0] && mii.mdio) begin
            n.bit_no = 5'd2;
            n.md_st = MD_FRAME;
          end
        end
      end
      MD_FRAME: begin
        if (mrise) begin
          n.sr = {s.sr[14:0], mii.mdio};
          n.bit_no = s.bit_no + 5'h1;
          if (s.bit_no == 5'd13) begin
            n.is_rd = (n.sr[11:10] == OP_RD) && (n.sr[9:5] == PHY_ADDR);
            n.is_wr = (n.sr[11:10] == OP_WR) && (n.sr[9:5] == PHY_ADDR);
            n.rad = n.sr[4:0];
            n.osr = {1'b0, rd_mux(n.sr[4:0])};
          end
          if (s.bit_no == 5'd14) begin
            n.drv = s.is_rd;
          end
          if (s.bit_no >= 5'd15 && s.bit_no <= 5'd30) begin
            n.osr = {s.osr[15:0], 1'b0};
          end
          if (s.bit_no == 5'd31) begin
            n.drv = 1'b0;
            n.md_st = MD_HUNT;
            if (s.is_wr && s.rad == REG_TEST) begin
              n.shadow_en = n.sr[SHADOW_EN_BIT];
              n.test_low = n.sr[5:0];
            end
            // depth changes only while the fifo is empty, so fill stays in range
            if (s.is_wr && s.rad == REG_FIFO_DEPTH && s.shadow_en && n.fill == 5'h0) begin
              n.depth = n.sr[3:0];
            end
            n.sr = 16'hffff;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in || !mii.hw_rst_n) begin
      s <= '0;
      s.depth <= DEPTH_RST;
      s.ph <= MII_LAST;
      s.test_low <= TEST_LOW_RST;
      s.sr <= 16'hffff;
    end else begin
      s <= n;
    end
  end

  assign mii.tx_clk = s.mii_clk;
  assign mii.rx_clk = s.mii_clk;
  assign mii.rx_dv = s.dv;
  assign mii.rx_er = s.er;
  assign mii.rxd = s.rxd;
  assign mii.crs = s.crs;
  assign mii.col = s.col;
  assign mii.mdio_p_out = s.osr[16];
  assign mii.mdio_p_oe_n = !s.drv;
  assign tx_valid_out = s.txv;
  assign tx_nibble_out = s.txn;
endmodule

/* pkg/prxd_pkg.sv */
// package of constants and helpers for the receive-diagnostic shadow register block
package prxd_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int       CLK_NS          = 10;
  localparam int       MII_PERIOD_NS   = 40;
  localparam int       MII_HIGH_NS     = 20;
  localparam logic [1:0] MII_LAST      = 2'((MII_PERIOD_NS / CLK_NS) - 1);
  localparam logic [1:0] MII_HALF      = 2'(MII_HIGH_NS / CLK_NS);
  localparam int       RXDV_LEAD_NS    = 60;
  localparam logic [2:0] RXDV_LEAD_CYC = 3'((RXDV_LEAD_NS + CLK_NS - 1) / CLK_NS);
  localparam int       CRS_EOP_MIN_NS  = 60;
  localparam int       CRS_EOP_MAX_NS  = 240;
  localparam logic [2:0] CRS_EOP_CYC   = 3'((CRS_EOP_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam int       COL_MAX_NS      = 200;
  localparam int       COL_MAX_CYC     = COL_MAX_NS / CLK_NS;
  localparam int       RST_LEN_NS      = 400;
  localparam logic [13:0] RST_LEN_CYC  = 14'((RST_LEN_NS + CLK_NS - 1) / CLK_NS);
  localparam int       RESET_WAIT_US   = 100;
  localparam int       RESET_WAIT_CYC  = (RESET_WAIT_US * 1000) / CLK_NS;
  localparam logic [1:0] MDC_HALF_LAST = 2'h3;
  // ****************************************
  // management frame and register map
  // ****************************************
  localparam logic [4:0] PHY_ADDR        = 5'h01;
  localparam logic [1:0] OP_RD           = 2'h2;
  localparam logic [1:0] OP_WR           = 2'h1;
  localparam logic [4:0] REG_LINE_QUALITY = 5'h1c;
  localparam logic [4:0] REG_FIFO_DEPTH  = 5'h1d;
  localparam logic [4:0] REG_PKT_LEN     = 5'h1e;
  localparam logic [4:0] REG_TEST        = 5'h1f;
  localparam int       SHADOW_EN_BIT     = 7;
  localparam logic [5:0] TEST_LOW_RST    = 6'h0b;
  localparam logic [3:0] DEPTH_RST       = 4'h4;
  localparam logic [3:0] DEPTH_MIN       = 4'h1;
  localparam logic [3:0] DEPTH_MAX       = 4'hd;
  localparam int       DEPTH_BASE_BITS   = 16;
  localparam int       DEPTH_STEP_BITS   = 4;
  localparam int       NIBBLE_BITS       = 4;
  // host command port
  localparam logic [7:0] HREG_CMD        = 8'h00;
  localparam logic [7:0] HREG_STAT       = 8'h04;
  localparam int       CMD_WRITE_BIT     = 24;

  // selected depth in nibbles; reserved codes clamp to the nearest legal one
  function automatic logic [4:0] depth_nibbles(input logic [3:0] code);
    logic [3:0] c;
    c = (code < DEPTH_MIN) ? DEPTH_MIN : ((code > DEPTH_MAX) ? DEPTH_MAX : code);
    return 5'((DEPTH_BASE_BITS + (int'(c) - 1) * DEPTH_STEP_BITS) / NIBBLE_BITS);
  endfunction
endpackage

/* pkg/prxd_mii_if.sv */
// interface joining the transceiver end and the mac and management end
`timescale 1ns/100ps
interface prxd_mii_if (
  input wire logic core_clk_in
);
  logic       tx_clk;
  logic       tx_en;
  logic [3:0] txd;
  logic       rx_clk;
  logic       rx_dv;
  logic       rx_er;
  logic [3:0] rxd;
  logic       crs;
  logic       col;
  logic       mdc;
  logic       mdio_h_out;
  logic       mdio_h_oe_n;
  logic       mdio_p_out;
  logic       mdio_p_oe_n;
  logic       mdio;
  logic       hw_rst_n;

  // open line with pull-up
  assign mdio = !mdio_p_oe_n ? mdio_p_out : (!mdio_h_oe_n ? mdio_h_out : 1'b1);

  modport phy (
    input  tx_en, txd, mdc, mdio, hw_rst_n,
    output tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col, mdio_p_out, mdio_p_oe_n
  );
  modport mac (
    input  tx_clk, rx_clk, rx_dv, rx_er, rxd, crs, col, mdio,
    output tx_en, txd, mdc, mdio_h_out, mdio_h_oe_n, hw_rst_n
  );
endinterface

/* rtl/prxd_mac.sv */
// mac and management end: reset sequencing, management frames, mii sampling
`timescale 1ns/100ps
module prxd_mac
  import prxd_pkg::*;
#(
  parameter int RESET_WAIT = RESET_WAIT_CYC
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_n_in,
  prxd_mii_if.mac          mii,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  input  wire logic        tx_en_in,
  input  wire logic [3:0]  tx_nibble_in,
  output logic             tx_take_out,
  output logic             rx_valid_out,
  output logic      [3:0]  rx_nibble_out,
  output logic             rx_err_out,
  output logic             crs_out,
  output logic             col_out
);
  typedef enum logic [1:0] {H_RST, H_WAIT, H_IDLE, H_FRAME} prxd_hst_t;
  typedef struct packed {
    prxd_hst_t   st;
    logic [13:0] cnt;
    logic        phy_rst_n;
    logic        mdc;
    logic [1:0]  div;
    logic [5:0]  idx;
    logic [63:0] fsr;
    logic        is_rd;
    logic        oe_n;
    logic [15:0] rdata;
    logic [31:0] rdo;
    logic        tclk_q;
    logic        rclk_q;
    logic        tx_en;
    logic [3:0]  txd;
    logic        take;
    logic        rxv;
    logic [3:0]  rxn;
    logic        rxe;
    logic        crs;
    logic        col;
  } prxd_mac_st_t;

  prxd_mac_st_t s;
  prxd_mac_st_t n;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    n.take = 1'b0;
    n.rxv = 1'b0;
    n.rdo = 32'h0;
    n.tclk_q = mii.tx_clk;
    n.rclk_q = mii.rx_clk;
    n.crs = mii.crs;
    n.col = mii.col;
    // launch transmit on the falling tx clock so the device samples on rising
    if (!mii.tx_clk && s.tclk_q) begin
      n.tx_en = tx_en_in;
      n.txd = tx_nibble_in;
      n.take = tx_en_in;
    end
    if (mii.rx_clk && !s.rclk_q) begin
      n.rxv = mii.rx_dv;
      n.rxn = mii.rxd;
      n.rxe = mii.rx_er;
    end
    unique case (s.st)
      H_RST: begin
        n.phy_rst_n = 1'b0;
        if (s.cnt == RST_LEN_CYC - 14'h1) begin
          n.cnt = 14'h0;
          n.phy_rst_n = 1'b1;
          n.st = H_WAIT;
        end else begin
          n.cnt = s.cnt + 14'h1;
        end
      end
      H_WAIT: begin
        if (s.cnt == 14'(RESET_WAIT - 1)) begin
          n.st = H_IDLE;
        end else begin
          n.cnt = s.cnt + 14'h1;
        end
      end
      H_IDLE: begin
        n.mdc = 1'b0;
        n.oe_n = 1'b1;
        if (reg_wr_in && reg_addr_in == HREG_CMD) begin
          n.is_rd = !reg_wdata_in[CMD_WRITE_BIT];
          n.fsr = {32'hffffffff, 2'h1,
                   reg_wdata_in[CMD_WRITE_BIT] ? OP_WR : OP_RD, PHY_ADDR,
                   reg_wdata_in[20:16], reg_wdata_in[CMD_WRITE_BIT] ? 2'h2 : 2'h3,
                   reg_wdata_in[15:0]};
          n.idx = 6'h0;
          n.div = 2'h0;
          n.oe_n = 1'b0;
          n.st = H_FRAME;
        end
      end
      H_FRAME: begin
        n.div = s.div + 2'h1;
        if (s.div == MDC_HALF_LAST) begin
          n.div = 2'h0;
          if (!s.mdc) begin
            n.mdc = 1'b1;
            if (s.is_rd && s.idx >= 6'd48) begin
              n.rdata = {s.rdata[14:0], mii.mdio};
            end
            if (s.idx == 6'd63) begin
              n.st = H_IDLE;
            end
          end else begin
            n.mdc = 1'b0;
            n.idx = s.idx + 6'h1;
            n.fsr = {s.fsr[62:0], 1'b1};
            n.oe_n = s.is_rd && (s.idx >= 6'd45);
          end
        end
      end
    endcase
    if (reg_rd_in && reg_addr_in == HREG_STAT) begin
      n.rdo = {s.rdata, 14'h0, s.st == H_IDLE, s.st == H_FRAME};
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      s <= '0;
      s.oe_n <= 1'b1;
      s.fsr <= '1;
    end else begin
      s <= n;
    end
  end

  assign mii.tx_en = s.tx_en;
  assign mii.txd = s.txd;
  assign mii.mdc = s.mdc;
  assign mii.mdio_h_out = s.fsr[63];
  assign mii.mdio_h_oe_n = s.oe_n;
  assign mii.hw_rst_n = s.phy_rst_n;
  assign reg_rdata_out = s.rdo;
  assign tx_take_out = s.take;
  assign rx_valid_out = s.rxv;
  assign rx_nibble_out = s.rxn;
  assign rx_err_out = s.rxe;
  assign crs_out = s.crs;
  assign col_out = s.col;
endmodule

/* dv/prxd_checker.sv */
// checker of the mii link between the two ends
`timescale 1ns/100ps
module prxd_checker
  import prxd_pkg::*;
#(
  parameter int RESET_WAIT = 50
) (
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic       hw_rst_n,
  input wire logic       tx_clk,
  input wire logic       rx_clk,
  input wire logic       tx_en,
  input wire logic [3:0] txd,
  input wire logic       rx_dv,
  input wire logic       rx_er,
  input wire logic [3:0] rxd,
  input wire logic       crs,
  input wire logic       col,
  input wire logic       mdc
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [15:0] low_cnt;
  logic [15:0] wait_cnt;
  logic [5:0]  col_cnt;
  always_ff @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      low_cnt  <= '0;
      wait_cnt <= '0;
      col_cnt  <= '0;
    end else begin
      low_cnt  <= hw_rst_n ? '0 : low_cnt + 16'h0001;
      wait_cnt <= !hw_rst_n ? '0 : ((&wait_cnt) ? wait_cnt : wait_cnt + 16'h0001);
      col_cnt  <= (crs && tx_en && !col) ? col_cnt + 6'h01 : '0;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rx_clk_free: assert property (disable iff (!rst_n_in || !hw_rst_n)
    $rose(rx_clk) |=> rx_clk ##1 !rx_clk [*2] ##1 rx_clk)
    else $error("rx clock period broken");
  a_tx_clk_period: assert property (disable iff (!rst_n_in || !hw_rst_n)
    $fell(tx_clk) |-> !tx_clk ##1 !tx_clk ##1 tx_clk)
    else $error("tx clock period broken");
  a_tx_data_launch: assert property (disable iff (!rst_n_in || !hw_rst_n)
    ($changed(txd) || $changed(tx_en)) |-> !tx_clk && !$past(tx_clk))
    else $error("tx data moved near rising tx clock");
  a_rx_fall_launch: assert property (disable iff (!rst_n_in || !hw_rst_n)
    ($changed(rxd) || $changed(rx_dv) || $changed(rx_er)) |-> $fell(rx_clk))
    else $error("rx data moved off falling rx clock");
  a_crs_before_dv: assert property (disable iff (!rst_n_in || !hw_rst_n)
    $rose(rx_dv) |-> crs && $past(crs, 6))
    else $error("rx valid without carrier lead");
  a_col_bound: assert property (disable iff (!rst_n_in || !hw_rst_n)
    col_cnt <= 6'(COL_MAX_CYC))
    else $error("collision late");
  a_hw_rst_len: assert property ($rose(hw_rst_n) |-> low_cnt >= 16'(RST_LEN_CYC))
    else $error("hardware reset too short");
  a_reset_wait: assert property ($rose(mdc) |-> wait_cnt >= 16'(RESET_WAIT))
    else $error("management activity too early");
  c_rx_frame: cover property ($rose(rx_dv));
  c_collision: cover property ($rose(col));
  c_mgmt_frame: cover property ($rose(mdc));
endmodule

/* dv/testbench.sv */
// self-checking testbench of both ends joined over the mii link
`timescale 1ns/100ps
module testbench
  import prxd_pkg::*;
;
  localparam int WAIT = 50;
  logic        core_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        link_up_in = 1'b0;
  logic [7:0]  noise_in = 8'h00;
  logic        line_active_in = 1'b0;
  logic        line_wr_in = 1'b0;
  logic [3:0]  line_nibble_in = 4'h0;
  logic        line_err_in = 1'b0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic        reg_wr_in = 1'b0;
  logic        reg_rd_in = 1'b0;
  logic        tx_en_in = 1'b0;
  logic [3:0]  tx_nibble_in = 4'h0;
  logic        line_ready_out, tx_valid_out, tx_take_out, rx_valid_out, rx_err_out;
  logic        crs_out, col_out, col_seen;
  logic [3:0]  tx_nibble_out, rx_nibble_out;
  logic [31:0] reg_rdata_out;
  logic [4:0]  sq[$], gq[$];
  logic [3:0]  tq[$], uq[$];
  int          error_cnt = 0;
  int          n_checks = 0;
  int          seed = 68;
  always #5 core_clk_in = ~core_clk_in;
  prxd_mii_if mii (.core_clk_in(core_clk_in));
  prxd_phy prxd_phy_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .mii(mii),
    .link_up_in(link_up_in), .noise_in(noise_in), .line_active_in(line_active_in),
    .line_wr_in(line_wr_in), .line_nibble_in(line_nibble_in), .line_err_in(line_err_in),
    .line_ready_out(line_ready_out), .tx_valid_out(tx_valid_out),
    .tx_nibble_out(tx_nibble_out));
  prxd_mac #(.RESET_WAIT(WAIT)) prxd_mac_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .mii(mii), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .tx_en_in(tx_en_in), .tx_nibble_in(tx_nibble_in), .tx_take_out(tx_take_out),
    .rx_valid_out(rx_valid_out), .rx_nibble_out(rx_nibble_out), .rx_err_out(rx_err_out),
    .crs_out(crs_out), .col_out(col_out));
  prxd_checker #(.RESET_WAIT(WAIT)) prxd_checker_i (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .hw_rst_n(mii.hw_rst_n), .tx_clk(mii.tx_clk), .rx_clk(mii.rx_clk),
    .tx_en(mii.tx_en), .txd(mii.txd), .rx_dv(mii.rx_dv), .rx_er(mii.rx_er), .rxd(mii.rxd),
    .crs(mii.crs), .col(mii.col), .mdc(mii.mdc));
  // ****************************************
  // helpers
  // ****************************************
  function automatic int depth_exp(input int c);
    return (16 + (c - 1) * 4) / 4;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic host(input logic [7:0] a, input logic [31:0] d, input logic wr,
                      output logic [31:0] q);
    @(posedge core_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= wr;
    reg_rd_in    <= !wr;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    #1 q = reg_rdata_out;
  endtask
  task automatic idle(output logic [31:0] s);
    int n;
    n = 0;
    do begin
      host(HREG_STAT, 32'h0, 1'b0, s);
      n++;
    end while (s[1] !== 1'b1 && n < 2000);
    if (s[1] !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic mdio(input logic [4:0] r, input logic [15:0] d, input logic wr,
                      output logic [15:0] q);
    logic [31:0] s;
    idle(s);
    host(HREG_CMD, {7'h00, wr, 3'h0, r, d}, 1'b1, s);
    idle(s);
    q = s[31:16];
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ****************************************
  // monitors and tx source
  // ****************************************
  always @(posedge core_clk_in) begin
    if (rx_valid_out) gq.push_back({rx_err_out, rx_nibble_out});
    if (tx_valid_out) uq.push_back(tx_nibble_out);
    if (col_out) col_seen = 1'b1;
    if (tx_take_out) begin
      tq.push_back(tx_nibble_in);
      tx_nibble_in <= 4'($random(seed));
    end
  end
  initial begin
    repeat (80000) @(posedge core_clk_in);
    error_cnt++;
    conclude();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [15:0] q;
    int n;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    mdio(REG_TEST, 16'h0, 1'b0, q);
    chk(q, 32'h000b);
    for (n = 0; n < 3; n++) begin
      mdio(REG_LINE_QUALITY + 5'(n), 16'h0, 1'b0, q);
      chk(q, 32'h0);
    end
    mdio(REG_FIFO_DEPTH, 16'h0009, 1'b1, q);
    mdio(REG_TEST, 16'h008b, 1'b1, q);
    mdio(REG_TEST, 16'h0, 1'b0, q);
    chk(q, 32'h008b);
    mdio(REG_FIFO_DEPTH, 16'h0, 1'b0, q);
    chk(q, 32'h0004);
    mdio(REG_PKT_LEN, 16'h0, 1'b0, q);
    chk(q, 32'h0);
    for (int code = 1; code <= 13; code++) begin
      mdio(REG_FIFO_DEPTH, 16'(code), 1'b1, q);
      mdio(REG_FIFO_DEPTH, 16'h0, 1'b0, q);
      chk(q, 32'(code));
      sq.delete();
      gq.delete();
      @(posedge core_clk_in);
      link_up_in <= 1'($random(seed));
      noise_in   <= 8'($random(seed));
      repeat (20) begin
        line_wr_in     <= 1'b1;
        line_nibble_in <= 4'($random(seed));
        line_err_in    <= 1'($random(seed));
        #1;
        if (line_ready_out === 1'b1) sq.push_back({line_err_in, line_nibble_in});
        @(posedge core_clk_in);
      end
      line_wr_in <= 1'b0;
      chk(sq.size(), depth_exp(code));
      mdio(REG_LINE_QUALITY, 16'h0, 1'b0, q);
      chk(q & 16'hff0f, {link_up_in ? noise_in : 8'h00, 4'h0,
        4'(depth_exp(code) > 15 ? 15 : depth_exp(code))});
      @(posedge core_clk_in);
      col_seen = 1'b0;
      tx_en_in       <= 1'b1;
      line_active_in <= 1'b1;
      n = 0;
      // line goes quiet while the last nibble is still queued, so rx valid ends cleanly
      while (gq.size() + 1 < sq.size() && n < 500) begin
        @(posedge core_clk_in);
        n++;
      end
      chk(32'(crs_out), 32'h1);
      line_active_in <= 1'b0;
      n = 0;
      while (mii.crs === 1'b1 && n < 40) begin
        @(posedge core_clk_in);
        #1 n++;
      end
      chk(32'(n >= 6 && n <= 24), 32'h1);
      chk(32'(col_seen), 32'h1);
      @(posedge core_clk_in);
      tx_en_in <= 1'b0;
      repeat (40) @(posedge core_clk_in);
      chk(32'(crs_out), 32'h0);
      chk(gq.size(), sq.size());
      foreach (sq[i]) if (i < gq.size()) chk(gq[i], sq[i]);
      mdio(REG_PKT_LEN, 16'h0, 1'b0, q);
      if (link_up_in) chk(q, 32'(sq.size() / 2));
    end
    chk(uq.size(), tq.size());
    foreach (tq[i]) if (i < uq.size()) chk(uq[i], tq[i]);
    conclude();
  end
endmodule
